// file: core/kq_top.sv
// Keypad event queue: encodes matrix and general-purpose input events into
// one-byte codes, queues them and serves them to software over AHB-Lite.
// Assumes the key scanner delivers one-cycle matrix event strobes, a single
// AHB-Lite master, and all inputs synchronous to SYS_CLK_IN.
//
// How it works
// - Matrix holds at most ten columns by eight rows, eighty keys.
// - Only lines selected in the line select registers join the matrix.
// - Matrix key number is ten times row plus column plus one.
// - Row inputs report key numbers 97 through 104.
// - Column inputs report key numbers 105 through 114.
// - Input press is taken when the line reaches its configured active level.
// - After a press, return to the idle level records a release.
// - Code bit 7 is one for press, zero for release.
// - Code bits 6 to 0 hold the key number.
// - Locked with lock mask set, input events are neither counted nor stored.
// - The queue holds at most ten one-byte events.
// - An input line queues events only when its event enable bit is one.
// - Queued event count reads in bits 3 to 0 of the lock register.
// - Reading the head returns the oldest event and pops it.
// - An empty queue reads count zero and head zero.
// - Status holds a key event flag and an input event flag.
// - Writing one to a status bit clears it.
// - An event arriving with ten entries queued and no head pop in that cycle sets the overflow flag.
// - Overflow pulls the interrupt low when its enable bit is set.
// - The overflow policy bit picks one of two overflow behaviours.
// - Policy one pushes the oldest entry out; policy zero drops the new.
// - Lock bit 6 suppresses matrix event recording and matrix event interrupts.
`timescale 1ns/1ps
module kq_top (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        MATRIX_EVT_VALID_IN,
    input  wire logic [2:0]  MATRIX_ROW_IN,
    input  wire logic [3:0]  MATRIX_COL_IN,
    input  wire logic        MATRIX_PRESS_IN,
    input  wire logic [7:0]  ROW_PIN_IN,
    input  wire logic [9:0]  COL_PIN_IN,
    output logic      [7:0]  MATRIX_ROW_SELECT_OUT,
    output logic      [9:0]  MATRIX_COL_SELECT_OUT,
    output logic             KEYPAD_LOCKED_OUT,
    output logic             IRQ_N_OUT,
    output logic             IRQ_OE_OUT
);

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } kq_bus_state_type;

    // ----------------------------------------------------------------
    // Register index decode
    // ----------------------------------------------------------------
    function automatic logic [5:0] kq_index(input logic [31:0] addr);
        kq_index = addr[kq_pkg::ADDR_LSB +: 6];
    endfunction : kq_index

    kq_bus_state_type bus_state;
    kq_bus_state_type next_bus_state;
    logic [5:0]       bus_index;
    logic [5:0]       next_bus_index;
    logic             bus_word;
    logic             next_bus_word;
    logic [31:0]      rdata;
    logic [31:0]      next_rdata;
    logic             accept;
    logic             wr_en;
    logic             pop;

    logic [7:0]       config_reg;
    logic [7:0]       next_config_reg;
    logic [7:0]       row_select;
    logic [7:0]       next_row_select;
    logic [9:0]       col_select;
    logic [9:0]       next_col_select;
    logic [7:0]       row_evt_en;
    logic [7:0]       next_row_evt_en;
    logic [9:0]       col_evt_en;
    logic [9:0]       next_col_evt_en;
    logic [7:0]       row_level;
    logic [7:0]       next_row_level;
    logic [9:0]       col_level;
    logic [9:0]       next_col_level;
    logic             locked;
    logic             next_locked;
    logic             key_flag;
    logic             next_key_flag;
    logic             input_flag;
    logic             next_input_flag;
    logic             ovf_flag;
    logic             next_ovf_flag;
    logic             irq_n;
    logic             next_irq_n;

    logic             matrix_push;
    logic [7:0]       matrix_code;
    logic             push;
    logic [7:0]       push_code;
    logic [7:0]       head;
    logic [3:0]       count;
    logic             overflow;

    kq_event_if       gpi_evt ();

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    always_comb begin
        // Out-of-range strobes and unselected lines are dropped here.
        matrix_push = MATRIX_EVT_VALID_IN && !locked
                      && MATRIX_ROW_IN <= kq_pkg::ROW_LAST
                      && MATRIX_COL_IN <= kq_pkg::COL_LAST
                      && row_select[MATRIX_ROW_IN]
                      && col_select[MATRIX_COL_IN];
        matrix_code = {MATRIX_PRESS_IN,
                       7'(MATRIX_ROW_IN) * kq_pkg::KEY_COLS + 7'(MATRIX_COL_IN)
                       + kq_pkg::KEY_FIRST};
        // Matrix strobes last one cycle, so they win; inputs hold their change.
        gpi_evt.ready = !matrix_push;
        push          = matrix_push || gpi_evt.valid;
        push_code     = matrix_push ? matrix_code : gpi_evt.code;
    end

    kq_input_events u_inputs (
        .clk_in         (SYS_CLK_IN),
        .resetn_in      (RESETN_IN),
        .pin_in         ({COL_PIN_IN, ROW_PIN_IN}),
        .enable_in      ({col_evt_en, row_evt_en}),
        .active_high_in ({col_level, row_level}),
        .suppress_in    (locked && config_reg[kq_pkg::CFG_LOCK_MASK]),
        .evt            (gpi_evt)
    );

    kq_event_fifo u_fifo (
        .clk_in       (SYS_CLK_IN),
        .resetn_in    (RESETN_IN),
        .push_in      (push),
        .code_in      (push_code),
        .pop_in       (pop),
        .policy_in    (config_reg[kq_pkg::CFG_OVF_POLICY]),
        .head_out     (head),
        .count_out    (count),
        .overflow_out (overflow)
    );

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // Reads take one wait state so the answer reflects any write that
    // completed just before, and so the pop lands on a known edge.
    always_comb begin
        accept         = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
        next_bus_state = bus_state;
        next_bus_index = bus_index;
        next_bus_word  = bus_word;
        next_rdata     = rdata;
        wr_en          = 1'b0;
        pop            = 1'b0;
        unique case (bus_state)
            BUS_READ_WAIT: begin
                next_bus_state = BUS_READ_DONE;
                next_rdata     = 32'h0000_0000;
                unique case (bus_index)
                    kq_pkg::IDX_CONFIG:     next_rdata[7:0] = config_reg;
                    kq_pkg::IDX_IRQ_STATUS: begin
                        next_rdata[kq_pkg::STAT_KEY_FLAG]   = key_flag;
                        next_rdata[kq_pkg::STAT_INPUT_FLAG] = input_flag;
                        next_rdata[kq_pkg::STAT_OVF_FLAG]   = ovf_flag;
                    end
                    kq_pkg::IDX_LOCK_COUNT: begin
                        next_rdata[kq_pkg::LOCK_BIT] = locked;
                        next_rdata[3:0]              = count;
                    end
                    kq_pkg::IDX_QUEUE_HEAD: begin
                        next_rdata[7:0] = head;
                        pop             = 1'b1;
                    end
                    kq_pkg::IDX_ROW_SELECT: next_rdata[7:0] = row_select;
                    kq_pkg::IDX_COL_SELECT: next_rdata[9:0] = col_select;
                    kq_pkg::IDX_ROW_EVT_EN: next_rdata[7:0] = row_evt_en;
                    kq_pkg::IDX_COL_EVT_EN: next_rdata[9:0] = col_evt_en;
                    kq_pkg::IDX_ROW_LEVEL:  next_rdata[7:0] = row_level;
                    kq_pkg::IDX_COL_LEVEL:  next_rdata[9:0] = col_level;
                    default:                next_rdata      = 32'h0000_0000;
                endcase
            end
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                wr_en = (bus_state == BUS_WRITE) && bus_word;
                if (accept) begin
                    next_bus_index = kq_index(HADDR_IN);
                    next_bus_word  = (HSIZE_IN == kq_pkg::HSIZE_WORD);
                    next_bus_state = HWRITE_IN ? BUS_WRITE : BUS_READ_WAIT;
                end else begin
                    next_bus_state = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            bus_state <= BUS_IDLE;
            bus_index <= 6'h00;
            bus_word  <= 1'b0;
            rdata     <= 32'h0000_0000;
        end else begin
            bus_state <= next_bus_state;
            bus_index <= next_bus_index;
            bus_word  <= next_bus_word;
            rdata     <= next_rdata;
        end
    end

    assign HRDATA_OUT    = rdata;
    assign HREADYOUT_OUT = (bus_state != BUS_READ_WAIT);
    assign HRESP_OUT     = 1'b0;

    // ----------------------------------------------------------------
    // Registers, status flags and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        logic wr_status;
        wr_status       = wr_en && bus_index == kq_pkg::IDX_IRQ_STATUS;
        next_config_reg = config_reg;
        next_row_select = row_select;
        next_col_select = col_select;
        next_row_evt_en = row_evt_en;
        next_col_evt_en = col_evt_en;
        next_row_level  = row_level;
        next_col_level  = col_level;
        next_locked     = locked;
        if (wr_en) begin
            unique case (bus_index)
                kq_pkg::IDX_CONFIG:     next_config_reg = HWDATA_IN[7:0];
                kq_pkg::IDX_LOCK_COUNT: next_locked     = HWDATA_IN[kq_pkg::LOCK_BIT];
                kq_pkg::IDX_ROW_SELECT: next_row_select = HWDATA_IN[7:0];
                kq_pkg::IDX_COL_SELECT: next_col_select = HWDATA_IN[9:0];
                kq_pkg::IDX_ROW_EVT_EN: next_row_evt_en = HWDATA_IN[7:0];
                kq_pkg::IDX_COL_EVT_EN: next_col_evt_en = HWDATA_IN[9:0];
                kq_pkg::IDX_ROW_LEVEL:  next_row_level  = HWDATA_IN[7:0];
                kq_pkg::IDX_COL_LEVEL:  next_col_level  = HWDATA_IN[9:0];
                default:                next_locked     = locked;
            endcase
        end
        // A new event in the clearing cycle keeps its flag set.
        next_key_flag   = (key_flag && !(wr_status && HWDATA_IN[kq_pkg::STAT_KEY_FLAG]))
                          || matrix_push;
        next_input_flag = (input_flag && !(wr_status && HWDATA_IN[kq_pkg::STAT_INPUT_FLAG]))
                          || (gpi_evt.valid && gpi_evt.ready);
        next_ovf_flag   = (ovf_flag && !(wr_status && HWDATA_IN[kq_pkg::STAT_OVF_FLAG]))
                          || overflow;
        next_irq_n      = !(next_key_flag || next_input_flag
                            || (next_ovf_flag && next_config_reg[kq_pkg::CFG_OVF_IRQ_EN]));
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            config_reg <= kq_pkg::RST_CONFIG;
            row_select <= kq_pkg::RST_ROWS;
            col_select <= kq_pkg::RST_COLS;
            row_evt_en <= kq_pkg::RST_ROWS;
            col_evt_en <= kq_pkg::RST_COLS;
            row_level  <= kq_pkg::RST_ROWS;
            col_level  <= kq_pkg::RST_COLS;
            locked     <= 1'b0;
            key_flag   <= 1'b0;
            input_flag <= 1'b0;
            ovf_flag   <= 1'b0;
            irq_n      <= 1'b1;
        end else begin
            config_reg <= next_config_reg;
            row_select <= next_row_select;
            col_select <= next_col_select;
            row_evt_en <= next_row_evt_en;
            col_evt_en <= next_col_evt_en;
            row_level  <= next_row_level;
            col_level  <= next_col_level;
            locked     <= next_locked;
            key_flag   <= next_key_flag;
            input_flag <= next_input_flag;
            ovf_flag   <= next_ovf_flag;
            irq_n      <= next_irq_n;
        end
    end

    assign MATRIX_ROW_SELECT_OUT = row_select;
    assign MATRIX_COL_SELECT_OUT = col_select;
    assign KEYPAD_LOCKED_OUT     = locked;
    // Open-drain: the pin is only ever driven low.
    assign IRQ_N_OUT             = irq_n;
    assign IRQ_OE_OUT            = !irq_n;

endmodule : kq_top

// file: pkg/kq_pkg.sv
// Constants shared by the keypad event queue: register indices, field positions,
// reset values, key numbering and queue geometry.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
package kq_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CONFIG      = 6'h01;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h02;
    localparam logic [5:0] IDX_LOCK_COUNT  = 6'h03;
    localparam logic [5:0] IDX_QUEUE_HEAD  = 6'h04;
    localparam logic [5:0] IDX_ROW_SELECT  = 6'h05;
    localparam logic [5:0] IDX_COL_SELECT  = 6'h06;
    localparam logic [5:0] IDX_ROW_EVT_EN  = 6'h07;
    localparam logic [5:0] IDX_COL_EVT_EN  = 6'h08;
    localparam logic [5:0] IDX_ROW_LEVEL   = 6'h09;
    localparam logic [5:0] IDX_COL_LEVEL   = 6'h0A;
    localparam int         ADDR_LSB        = 2;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_OVF_IRQ_EN   = 0;
    localparam int CFG_OVF_POLICY   = 1;
    localparam int CFG_LOCK_MASK    = 2;
    localparam int STAT_KEY_FLAG    = 0;
    localparam int STAT_INPUT_FLAG  = 1;
    localparam int STAT_OVF_FLAG    = 3;
    localparam int LOCK_BIT         = 6;
    localparam int EVT_PRESS_BIT    = 7;

    // ----------------------------------------------------------------
    // Geometry and key numbering
    // ----------------------------------------------------------------
    localparam int         ROWS        = 8;
    localparam int         COLS        = 10;
    localparam int         LINES       = ROWS + COLS;
    localparam int         DEPTH       = 10;
    localparam logic [3:0] DEPTH_COUNT = 4'hA;
    localparam logic [6:0] KEY_FIRST   = 7'h01;
    localparam logic [6:0] KEY_COLS    = 7'h0A;
    localparam logic [6:0] GPI_BASE    = 7'h61;
    localparam logic [2:0] ROW_LAST    = 3'h7;
    localparam logic [3:0] COL_LAST    = 4'h9;
    localparam logic [2:0] HSIZE_WORD  = 3'h2;
    localparam logic [7:0] EMPTY_CODE  = 8'h00;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CONFIG  = 8'h00;
    localparam logic [7:0] RST_ROWS    = 8'h00;
    localparam logic [9:0] RST_COLS    = 10'h000;

endpackage : kq_pkg

// file: pkg/kq_event_if.sv
// Event hand-off from the input watcher to the queue owner.
// Assumes both ends share one clock; an event is taken when valid and ready are high.
`timescale 1ns/1ps
interface kq_event_if;
    logic       valid;
    logic       ready;
    logic [7:0] code;

    modport source (output valid, output code, input ready);
    modport sink   (input valid, input code, output ready);
endinterface : kq_event_if

// file: core/kq_event_fifo.sv
// Ten-entry shift queue of event codes; the oldest entry always sits at the head.
// Assumes at most one push and one pop request per clock.
`timescale 1ns/1ps
module kq_event_fifo (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       push_in,
    input  wire logic [7:0] code_in,
    input  wire logic       pop_in,
    input  wire logic       policy_in,
    output logic      [7:0] head_out,
    output logic      [3:0] count_out,
    output logic            overflow_out
);

    logic [7:0] entries      [kq_pkg::DEPTH];
    logic [7:0] next_entries [kq_pkg::DEPTH];
    logic [3:0] count;
    logic [3:0] next_count;
    logic       next_overflow;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] held;
        held          = count;
        next_entries  = entries;
        next_overflow = 1'b0;
        // Vacated slots fill with zero so an empty head reads zero.
        if (pop_in && count != 4'h0) begin
            for (int i = 0; i < kq_pkg::DEPTH - 1; i++) begin
                next_entries[i] = entries[i + 1];
            end
            next_entries[kq_pkg::DEPTH - 1] = kq_pkg::EMPTY_CODE;
            held = count - 4'h1;
        end
        next_count = held;
        if (push_in) begin
            if (held < kq_pkg::DEPTH_COUNT) begin
                next_entries[held] = code_in;
                next_count = held + 4'h1;
            end else begin
                next_overflow = 1'b1;
                if (policy_in) begin
                    for (int i = 0; i < kq_pkg::DEPTH - 1; i++) begin
                        next_entries[i] = entries[i + 1];
                    end
                    next_entries[kq_pkg::DEPTH - 1] = code_in;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < kq_pkg::DEPTH; i++) begin
                entries[i] <= kq_pkg::EMPTY_CODE;
            end
            count        <= 4'h0;
            overflow_out <= 1'b0;
        end else begin
            entries      <= next_entries;
            count        <= next_count;
            overflow_out <= next_overflow;
        end
    end

    assign head_out  = entries[0];
    assign count_out = count;

endmodule : kq_event_fifo

// file: core/kq_input_events.sv
// Watches the eighteen row and column lines used as general-purpose inputs and
// offers one press or release event at a time, lowest line first.
// Assumes pin levels are synchronous and already debounced.
`timescale 1ns/1ps
module kq_input_events (
    input  wire logic                     clk_in,
    input  wire logic                     resetn_in,
    input  wire logic [kq_pkg::LINES-1:0] pin_in,
    input  wire logic [kq_pkg::LINES-1:0] enable_in,
    input  wire logic [kq_pkg::LINES-1:0] active_high_in,
    input  wire logic                     suppress_in,
    kq_event_if.source                    evt
);

    logic [kq_pkg::LINES-1:0] active;
    logic [kq_pkg::LINES-1:0] reported;
    logic [kq_pkg::LINES-1:0] next_reported;
    logic [kq_pkg::LINES-1:0] pending;

    // ----------------------------------------------------------------
    // Per-line level and pending change
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < kq_pkg::LINES; g++) begin : g_line
            // Active level is high or low as configured per line.
            assign active[g]  = active_high_in[g] ? pin_in[g] : !pin_in[g];
            assign pending[g] = enable_in[g] && !suppress_in && (active[g] != reported[g]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pick and track
    // ----------------------------------------------------------------
    always_comb begin
        logic found;
        found         = 1'b0;
        evt.valid     = 1'b0;
        evt.code      = kq_pkg::EMPTY_CODE;
        // Lines that are disabled or masked follow the pin silently, so that
        // re-enabling them never replays a stale transition.
        next_reported = reported;
        for (int i = 0; i < kq_pkg::LINES; i++) begin
            if (!enable_in[i] || suppress_in) begin
                next_reported[i] = active[i];
            end
            if (pending[i] && !found) begin
                found     = 1'b1;
                evt.valid = 1'b1;
                evt.code  = {active[i], kq_pkg::GPI_BASE + 7'(i)};
                if (evt.ready) begin
                    // After a press the opposite level is armed for the release.
                    next_reported[i] = active[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reported <= '0;
        end else begin
            reported <= next_reported;
        end
    end

endmodule : kq_input_events

// file: tb/kq_assertions.sv
// Port-level checks on the keypad event queue top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module kq_assertions (
    input wire logic       SYS_CLK_IN,
    input wire logic       RESETN_IN,
    input wire logic       HSEL_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic       HWRITE_IN,
    input wire logic       HREADY_IN,
    input wire logic       HREADYOUT_OUT,
    input wire logic       MATRIX_EVT_VALID_IN,
    input wire logic [2:0] MATRIX_ROW_IN,
    input wire logic [3:0] MATRIX_COL_IN,
    input wire logic [7:0] MATRIX_ROW_SELECT_OUT,
    input wire logic [9:0] MATRIX_COL_SELECT_OUT,
    input wire logic       KEYPAD_LOCKED_OUT,
    input wire logic       IRQ_N_OUT,
    input wire logic       IRQ_OE_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    wire ta = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    wire wa = ta && HWRITE_IN;
    wire mv = MATRIX_EVT_VALID_IN && IRQ_N_OUT;
    wire ok = MATRIX_EVT_VALID_IN && !KEYPAD_LOCKED_OUT && MATRIX_COL_IN <= 4'h9
        && MATRIX_ROW_SELECT_OUT[MATRIX_ROW_IN] && MATRIX_COL_SELECT_OUT[MATRIX_COL_IN];
    sequence s_wait;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence
    a_oe_follows: assert property (IRQ_OE_OUT == !IRQ_N_OUT) else $error("oe");
    a_key_irq: assert property (ok |=> !IRQ_N_OUT) else $error("key irq");
    a_locked_drop: assert property (mv && KEYPAD_LOCKED_OUT |=> IRQ_N_OUT) else $error("lk");
    a_unsel_drop: assert property (mv && MATRIX_COL_IN <= 4'h9
        && !MATRIX_COL_SELECT_OUT[MATRIX_COL_IN] |=> IRQ_N_OUT) else $error("unsel");
    a_range_drop: assert property (mv && MATRIX_COL_IN > 4'h9 |=> IRQ_N_OUT) else $error("rng");
    a_read_wait: assert property (ta && !HWRITE_IN |=> s_wait) else $error("rd wait");
    a_write_nowait: assert property (wa |=> HREADYOUT_OUT) else $error("wr wait");
    a_irq_holds: assert property (!IRQ_N_OUT && !wa && !$past(wa) |=> !IRQ_N_OUT)
        else $error("irq released");
endmodule : kq_assertions

// file: tb/kq_host_model.sv
// Host processor model: single-word AHB-Lite master transfers.
// Assumes xfer is called just after a rising edge.
`timescale 1ns/1ps
module kq_host_model (
    input  wire logic        clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic             hsel_out,
    output logic      [31:0] haddr_out,
    output logic      [1:0]  htrans_out,
    output logic             hwrite_out,
    output logic      [31:0] hwdata_out
);
    initial begin
        hsel_out <= 1'b1;
        haddr_out <= 32'h0;
        htrans_out <= 2'h0;
        hwrite_out <= 1'b0;
        hwdata_out <= 32'h0;
    end
    task xfer(input logic w, input logic [5:0] i, input logic [31:0] d, output logic [31:0] q);
        htrans_out <= 2'h2;
        hwrite_out <= w;
        haddr_out <= {24'h0, i, 2'h0};
        do @(posedge clk_in); while (!hready_in);
        htrans_out <= 2'h0;
        hwdata_out <= d;
        do @(posedge clk_in); while (!hready_in);
        q = hrdata_in;
    endtask : xfer
endmodule : kq_host_model

// file: tb/keypad_event_queue_test.sv
// Self-checking bench for the keypad event queue top.
`timescale 1ns/1ps
`define CK(n,e,g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module keypad_event_queue_test;
    localparam logic [5:0] ST = kq_pkg::IDX_IRQ_STATUS, LC = kq_pkg::IDX_LOCK_COUNT;
    localparam logic [5:0] HD = kq_pkg::IDX_QUEUE_HEAD, CF = kq_pkg::IDX_CONFIG;
    logic clk = 0, rstn = 0, hsel, hwr, rdy, irq_n, oe, lkd, hresp, mv = 0, mp = 0;
    logic [1:0] htr;
    logic [2:0] mr = 0;
    logic [3:0] mc = 0;
    logic [7:0] rp = 8'h00, rsel;
    logic [9:0] cp = 10'h3FF, csel;
    logic [31:0] ha, hw, hr, q;
    int n_errors = 0, checks_done = 0;
    kq_top i_kq_top (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(ha),
        .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(kq_pkg::HSIZE_WORD), .HWDATA_IN(hw),
        .HREADY_IN(rdy), .HRDATA_OUT(hr), .HREADYOUT_OUT(rdy), .HRESP_OUT(hresp),
        .MATRIX_EVT_VALID_IN(mv), .MATRIX_ROW_IN(mr), .MATRIX_COL_IN(mc), .MATRIX_PRESS_IN(mp),
        .ROW_PIN_IN(rp), .COL_PIN_IN(cp), .MATRIX_ROW_SELECT_OUT(rsel),
        .MATRIX_COL_SELECT_OUT(csel), .KEYPAD_LOCKED_OUT(lkd), .IRQ_N_OUT(irq_n), .IRQ_OE_OUT(oe));
    kq_host_model i_kq_host_model (.clk_in(clk), .hready_in(rdy), .hrdata_in(hr),
        .hsel_out(hsel), .haddr_out(ha), .htrans_out(htr), .hwrite_out(hwr), .hwdata_out(hw));
    task wr(input logic [5:0] i, input logic [31:0] d);
        i_kq_host_model.xfer(1'b1, i, d, q);
    endtask : wr
    task rc(input string n, input logic [5:0] i, input logic [31:0] e);
        i_kq_host_model.xfer(1'b0, i, 32'h0, q);
        `CK(n, e, q)
    endtask : rc
    task key(input logic [2:0] r, input logic [3:0] c, input logic p);
        mr <= r; mc <= c; mp <= p; mv <= 1'b1;
        @(posedge clk); mv <= 1'b0; @(posedge clk);
    endtask : key
    task t_matrix;
        key(0, 0, 1); key(0, 15, 1);
        wr(kq_pkg::IDX_ROW_SELECT, 32'hFF); wr(kq_pkg::IDX_COL_SELECT, 32'h3FF);
        key(0, 0, 1); key(7, 9, 1); key(0, 0, 0);
        `CK("irq", 1'b0, irq_n)
        `CK("sel", {1'b0, 18'h3FFFF}, {hresp, csel, rsel})
        rc("stat", ST, 32'h1);
        rc("cnt", LC, 32'h3);
        rc("h0", HD, 32'h81);
        rc("h1", HD, 32'hD0);
        rc("h2", HD, 32'h01);
        rc("cnt0", LC, 32'h0);
        rc("hz", HD, 32'h0);
        wr(ST, 32'h1); rc("clr", ST, 32'h0);
        `CK("irqc", 1'b1, irq_n)
    endtask : t_matrix
    task t_gpi;
        wr(kq_pkg::IDX_ROW_LEVEL, 32'h1); wr(kq_pkg::IDX_ROW_EVT_EN, 32'h1);
        wr(kq_pkg::IDX_COL_EVT_EN, 32'h200);
        rp <= 8'h03; @(posedge clk); rp <= 8'h02; cp <= 10'h1FF; @(posedge clk); @(posedge clk);
        rc("g0", HD, 32'hE1);
        rc("g1", HD, 32'h61);
        rc("g2", HD, 32'hF2);
        rc("gz", HD, 32'h0);
        rc("gs", ST, 32'h2);
        wr(ST, 32'h2);
    endtask : t_gpi
    task t_ovf;
        wr(CF, 32'h1);
        for (int k = 0; k < 11; k++) key(3'(k % 8), 4'h0, 1'b1);
        rc("oc", LC, 32'hA);
        rc("os", ST, 32'h9);
        wr(ST, 32'h1); @(posedge clk); @(posedge clk);
        `CK("oirq", 1'b0, irq_n)
        rc("o0", HD, 32'h81);
        wr(CF, 32'h3); key(7, 9, 1); key(0, 0, 1);
        rc("o1", HD, 32'h95);
        repeat (8) i_kq_host_model.xfer(1'b0, HD, 32'h0, q);
        rc("ol", HD, 32'h81);
        wr(ST, 32'hB); wr(CF, 32'h0);
    endtask : t_ovf
    task t_lock;
        wr(LC, 32'h40); key(0, 0, 1);
        `CK("lk", 1'b1, lkd)
        rc("lc", LC, 32'h40);
        wr(CF, 32'h4); rp <= 8'h03; @(posedge clk); @(posedge clk);
        rc("lm", LC, 32'h40);
        `CK("li", 1'b1, irq_n)
    endtask : t_lock
    task wrap_up;
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial forever #50 clk = ~clk;
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_matrix; t_gpi; t_ovf; t_lock; wrap_up;
    end
    initial begin
        #1000000;
        n_errors++;
        wrap_up;
    end
endmodule : keypad_event_queue_test
bind kq_top kq_assertions i_kq_assertions (.SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN),
    .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
    .HREADYOUT_OUT(HREADYOUT_OUT), .MATRIX_EVT_VALID_IN(MATRIX_EVT_VALID_IN),
    .MATRIX_ROW_IN(MATRIX_ROW_IN), .MATRIX_COL_IN(MATRIX_COL_IN),
    .MATRIX_ROW_SELECT_OUT(MATRIX_ROW_SELECT_OUT), .MATRIX_COL_SELECT_OUT(MATRIX_COL_SELECT_OUT),
    .KEYPAD_LOCKED_OUT(KEYPAD_LOCKED_OUT), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_OE_OUT(IRQ_OE_OUT));
